// ---- common/psf_pkg.sv ----
// Constants and types shared by the power switch fault supervisor
// Contract
// - With supply up, gate follows command
// - Without driver supply, switch held off
// - Latched variant: overcurrent latches switch off
// - Latch clears after 350 us low or power loss
// - Per-cycle variant: fault clears when command low
// - Per-cycle: next rising command turns on normally
// - Ignore overcurrent during blanking after each transition
// - Blanking lengthens at lower slew rates
// - Over-temperature holds off until hysteresis clears
// - Fault output low until safety transistor on
// - Fault output low during overcurrent or over-temperature
// - Supply lockout blocks switching, fault output low
// - Low-power pin low sleeps; high ready within 1 ms
package psf_pkg;
  localparam int unsigned CLK_FREQ_HZ      = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 40;
  // Least low time to clear latched overcurrent, rounded up
  localparam int unsigned RESET_LOW_US     = 350;
  localparam int unsigned RESET_LOW_CYC    = (RESET_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest startup after wake, rounded down
  localparam int unsigned STARTUP_MS       = 1;
  localparam int unsigned STARTUP_CYC      = (STARTUP_MS * 1_000_000) / CLK_PERIOD_NS;
  // Blanking 20 ns at 100 V/ns, least one cycle
  localparam int unsigned BLANK_NS         = 20;
  localparam int unsigned BLANK_REF_SLEW   = 100;
  localparam int unsigned BLANK_BASE_CYC   = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEW_W           = 8;
  localparam logic [SLEW_W-1:0] SLEW_DEFAULT = 8'h64;
  localparam int unsigned BLANK_W          = 8;
  localparam logic        OVERCURRENT_LATCHED   = 1'h0;
  localparam logic        OVERCURRENT_PER_CYCLE = 1'h1;

  typedef enum logic [1:0] {
    PSF_OFF     = 2'b00,
    PSF_WAKE    = 2'b01,
    PSF_READY   = 2'b10
  } psf_state_t;
endpackage

// ---- common/psf_blank_if.sv ----
`timescale 1ns/100ps
// Blanking window request and status between supervisor and timer
interface psf_blank_if;
  logic                      edge_seen;
  logic [psf_pkg::SLEW_W-1:0] slew;
  logic                      active;
  modport sup   (output edge_seen, output slew, input active);
  modport timer (input edge_seen, input slew, output active);
endinterface

// ---- core/psf_blank_timer.sv ----
`timescale 1ns/100ps
// Overcurrent blanking timer scaled by drain slew rate
module psf_blank_timer (
  input  wire logic   clk_sys_i,
  input  wire logic   reset_i,
  psf_blank_if.timer  blk
);
  import psf_pkg::*;

  logic [BLANK_W-1:0] count_reg;
  logic [15:0]        len;
  logic [15:0]        slew_nz;

  // Length grows as slew falls below reference
  always_comb begin
    slew_nz = (blk.slew == '0) ? 16'h0001 : {8'h00, blk.slew};
    len     = 16'((BLANK_BASE_CYC * BLANK_REF_SLEW + 32'(slew_nz) - 1) / 32'(slew_nz));
    if (len == 16'h0000) begin
      len = 16'h0001;
    end
    if (len > 16'h00ff) begin
      len = 16'h00ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count_reg <= '0;
    end else if (blk.edge_seen) begin
      count_reg <= len[BLANK_W-1:0];
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign blk.active = blk.edge_seen || (count_reg != '0);
endmodule // psf_blank_timer

// ---- core/psf_supervisor.sv ----
`timescale 1ns/100ps
// Gate command and fault supervision of a single power switch
module psf_supervisor #(
  parameter int unsigned            RESET_LOW_CYCLES = psf_pkg::RESET_LOW_CYC,
  parameter int unsigned            STARTUP_CYCLES   = psf_pkg::STARTUP_CYC,
  parameter logic                   OVERCURRENT_MODE = psf_pkg::OVERCURRENT_LATCHED
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_i,
  input  wire logic                       gate_cmd_i,
  input  wire logic                       driver_supply_ok_i,
  input  wire logic                       all_supplies_ok_i,
  input  wire logic                       overcurrent_i,
  input  wire logic                       temp_trip_i,
  input  wire logic                       temp_below_hyst_i,
  input  wire logic                       low_power_pin_i,
  input  wire logic [psf_pkg::SLEW_W-1:0] drain_slew_i,
  output logic                            gate_drive_o,
  output logic                            safety_fet_on_o,
  output logic                            converter_en_o,
  output logic                            fault_n_o
);
  import psf_pkg::*;

  // Pin sample, state entry and output flop take three of the startup cycles
  localparam int unsigned WAKE_LAST = STARTUP_CYCLES - 3;

  psf_blank_if blk ();

  psf_blank_timer u_blank (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .blk       (blk)
  );

  psf_state_t  state_reg;
  logic [31:0] wake_cnt_reg;
  logic [31:0] low_cnt_reg;
  logic        cmd_prev_reg;
  logic        oc_latch_reg;
  logic        cyc_latch_reg;
  logic        temp_hold_reg;
  logic        ready;
  logic        oc_hit;
  logic        gate_next;
  logic        fault_any;

  assign ready = (state_reg == PSF_READY);

  // Power state: off, converter starting, ready
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_reg    <= PSF_OFF;
      wake_cnt_reg <= '0;
    end else if (!driver_supply_ok_i || !low_power_pin_i) begin
      state_reg    <= PSF_OFF;
      wake_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        PSF_OFF: begin
          state_reg    <= PSF_WAKE;
          wake_cnt_reg <= '0;
        end
        PSF_WAKE: begin
          if (wake_cnt_reg >= WAKE_LAST) begin
            state_reg <= PSF_READY;
          end
          wake_cnt_reg <= wake_cnt_reg + 32'h1;
        end
        PSF_READY: begin
          state_reg <= PSF_READY;
        end
        default: begin
          state_reg <= PSF_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmd_prev_reg <= 1'b0;
    end else begin
      cmd_prev_reg <= gate_cmd_i;
    end
  end

  assign blk.edge_seen = (gate_cmd_i != cmd_prev_reg);
  assign blk.slew      = drain_slew_i;
  assign oc_hit        = overcurrent_i && gate_drive_o && !blk.active;

  // Low time counter for latched clear
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || gate_cmd_i) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg < RESET_LOW_CYCLES) begin
      low_cnt_reg <= low_cnt_reg + 32'h1;
    end
  end

  // Latched overcurrent, set wins over low-time clear, not over supply loss
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !driver_supply_ok_i) begin
      oc_latch_reg <= 1'b0;
    end else if (OVERCURRENT_MODE == OVERCURRENT_LATCHED && oc_hit) begin
      oc_latch_reg <= 1'b1;
    end else if (low_cnt_reg >= RESET_LOW_CYCLES) begin
      oc_latch_reg <= 1'b0;
    end
  end

  // Per-cycle overcurrent, clears with command low
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cyc_latch_reg <= 1'b0;
    end else if (OVERCURRENT_MODE == OVERCURRENT_PER_CYCLE && oc_hit) begin
      cyc_latch_reg <= 1'b1;
    end else if (!gate_cmd_i) begin
      cyc_latch_reg <= 1'b0;
    end
  end

  // Over-temperature hold with hysteresis
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      temp_hold_reg <= 1'b0;
    end else if (temp_trip_i) begin
      temp_hold_reg <= 1'b1;
    end else if (temp_below_hyst_i) begin
      temp_hold_reg <= 1'b0;
    end
  end

  assign fault_any = oc_latch_reg || cyc_latch_reg || temp_hold_reg || temp_trip_i
                     || oc_hit || !all_supplies_ok_i;

  assign gate_next = ready && all_supplies_ok_i && gate_cmd_i && !fault_any;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      gate_drive_o    <= 1'b0;
      safety_fet_on_o <= 1'b0;
      converter_en_o  <= 1'b0;
      fault_n_o       <= 1'b0;
    end else begin
      gate_drive_o    <= gate_next;
      safety_fet_on_o <= ready;
      converter_en_o  <= driver_supply_ok_i && low_power_pin_i;
      fault_n_o       <= ready && !fault_any;
    end
  end
endmodule // psf_supervisor

// ---- test/psf_properties.sv ----
`timescale 1ns/100ps
// Port checker of the power switch fault supervisor
module psf_properties (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic gate_cmd_i,
  input wire logic driver_supply_ok_i,
  input wire logic all_supplies_ok_i,
  input wire logic overcurrent_i,
  input wire logic temp_trip_i,
  input wire logic temp_below_hyst_i,
  input wire logic low_power_pin_i,
  input wire logic gate_drive_o,
  input wire logic safety_fet_on_o,
  input wire logic fault_n_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  gate_low_a: assert property (!gate_cmd_i |=> !gate_drive_o) else $error("gate on without command");
  gate_ready_a: assert property (gate_drive_o |-> safety_fet_on_o) else $error("gate on while not ready");
  fault_ready_a: assert property (fault_n_o |-> safety_fet_on_o) else $error("fault line high early");
  no_supply_a: assert property (!driver_supply_ok_i [*2] |=> !gate_drive_o)
    else $error("gate on without supply");
  lockout_a: assert property (!all_supplies_ok_i [*2] |=> !gate_drive_o && !fault_n_o)
    else $error("lockout not honoured");
  temp_hold_a: assert property (temp_trip_i ##1 !temp_below_hyst_i [*3] |=> !gate_drive_o && !fault_n_o)
    else $error("temperature hold lost");
  // Eight on-cycles clear the longest blanking of the slew rates in use
  overcurrent_off_a: assert property (
    (gate_cmd_i && gate_drive_o) [*8] ##0 overcurrent_i |=> !gate_drive_o && !fault_n_o)
    else $error("overcurrent not shut off");
  sleep_off_a: assert property (!low_power_pin_i [*2] |=> !safety_fet_on_o && !fault_n_o)
    else $error("low power pin ignored");
  cover property ((gate_cmd_i && gate_drive_o) [*8] ##0 overcurrent_i);
  cover property ($rose(fault_n_o));
  cover property (temp_trip_i ##1 !temp_below_hyst_i);
endmodule // psf_properties
bind psf_supervisor psf_properties u_props (
  .clk_sys_i          (clk_sys_i),
  .reset_i            (reset_i),
  .gate_cmd_i         (gate_cmd_i),
  .driver_supply_ok_i (driver_supply_ok_i),
  .all_supplies_ok_i  (all_supplies_ok_i),
  .overcurrent_i      (overcurrent_i),
  .temp_trip_i        (temp_trip_i),
  .temp_below_hyst_i  (temp_below_hyst_i),
  .low_power_pin_i    (low_power_pin_i),
  .gate_drive_o       (gate_drive_o),
  .safety_fet_on_o    (safety_fet_on_o),
  .fault_n_o          (fault_n_o)
);

// ---- test/psf_ctrl_model.sv ----
`timescale 1ns/100ps
// Controller model driving the gate command and watching the fault line
module psf_ctrl_model (
  input  wire logic on_req_i,
  input  wire logic cut_i,
  input  wire logic fault_n_i,
  output logic      gate_cmd_o
);
  // Ends the on command at once on a fault when asked
  assign gate_cmd_o = on_req_i & (fault_n_i | ~cut_i);
endmodule // psf_ctrl_model

// ---- test/psf_supervisor_bench.sv ----
`timescale 1ns/100ps
// Self-checking bench of the power switch fault supervisor
module psf_supervisor_bench;
  import psf_pkg::*;
  logic clk_sys_i = 1'h0, reset_i = 1'h1, on_req = 1'h0, cut = 1'h0, sup_ok = 1'h1, all_ok = 1'h1;
  logic oc_in = 1'h0, trip = 1'h0, hyst = 1'h1, low_power_pin = 1'h0, cmd, gate, fet, conv, fault_n;
  logic cmd_cyc = 1'h0, gate_cyc, fault_n_cyc;
  logic [SLEW_W-1:0] slew = SLEW_DEFAULT;
  int error_cnt = 0, samples_checked = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  psf_supervisor #(.RESET_LOW_CYCLES(10), .STARTUP_CYCLES(20), .OVERCURRENT_MODE(OVERCURRENT_LATCHED)) u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .gate_cmd_i(cmd), .driver_supply_ok_i(sup_ok), .all_supplies_ok_i(all_ok), .overcurrent_i(oc_in),
    .temp_trip_i(trip), .temp_below_hyst_i(hyst), .low_power_pin_i(low_power_pin), .drain_slew_i(slew),
    .gate_drive_o(gate), .safety_fet_on_o(fet), .converter_en_o(conv), .fault_n_o(fault_n));
  // Per-cycle variant shares every input but its own gate command
  psf_supervisor #(.RESET_LOW_CYCLES(10), .STARTUP_CYCLES(20), .OVERCURRENT_MODE(OVERCURRENT_PER_CYCLE)) u_dut_cyc (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .gate_cmd_i(cmd_cyc), .driver_supply_ok_i(sup_ok), .all_supplies_ok_i(all_ok), .overcurrent_i(oc_in),
    .temp_trip_i(trip), .temp_below_hyst_i(hyst), .low_power_pin_i(low_power_pin), .drain_slew_i(slew),
    .gate_drive_o(gate_cyc), .safety_fet_on_o(), .converter_en_o(), .fault_n_o(fault_n_cyc));
  psf_ctrl_model u_ctrl (.on_req_i(on_req), .cut_i(cut), .fault_n_i(fault_n), .gate_cmd_o(cmd));
  task automatic chk(string nm, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Eight settled on-cycles before the overcurrent pulse
  task automatic trip_overcurrent();
    on_req = 1'h1;
    cyc(9);
    oc_in = 1'h1;
    cyc(1);
    oc_in = 1'h0;
  endtask
  // Bench startup of 20 cycles stands for the 1 ms bound
  task automatic t_start();
    cyc(30);
    chk("sleep ready", 1'h0, fet);
    chk("sleep converter", 1'h0, conv);
    low_power_pin = 1'h1;
    on_req = 1'h1;
    cyc(10);
    chk("wake gate", 1'h0, gate);
    chk("wake converter", 1'h1, conv);
    cyc(9);
    chk("wake fault_n", 1'h0, fault_n);
    cyc(1);
    chk("ready fault_n", 1'h1, fault_n);
    chk("ready fet", 1'h1, fet);
    chk("follow on", 1'h1, gate);
    on_req = 1'h0;
    cyc(2);
    chk("follow off", 1'h0, gate);
  endtask
  task automatic t_latch();
    trip_overcurrent();
    cyc(2);
    chk("latch gate", 1'h0, gate);
    chk("latch fault_n", 1'h0, fault_n);
    on_req = 1'h0;
    cyc(6);
    on_req = 1'h1;
    cyc(1);
    on_req = 1'h0;
    cyc(9);
    chk("early clear", 1'h0, fault_n);
    cyc(5);
    chk("low clear", 1'h1, fault_n);
  endtask
  task automatic t_supply();
    trip_overcurrent();
    sup_ok = 1'h0;
    cyc(3);
    chk("no supply gate", 1'h0, gate);
    chk("no supply fet", 1'h0, fet);
    chk("no supply converter", 1'h0, conv);
    sup_ok = 1'h1;
    cyc(26);
    chk("supply clear", 1'h1, gate);
  endtask
  task automatic t_temp();
    cut = 1'h1;
    trip = 1'h1;
    hyst = 1'h0;
    cyc(2);
    chk("temp gate", 1'h0, gate);
    chk("cut cmd", 1'h0, cmd);
    trip = 1'h0;
    all_ok = 1'h0;
    cyc(4);
    chk("hyst hold", 1'h0, fault_n);
    hyst = 1'h1;
    cyc(4);
    chk("lockout hold", 1'h0, fault_n);
    all_ok = 1'h1;
    cyc(26);
    chk("all clear", 1'h1, gate);
  endtask
  // Slow slew stretches blanking to four cycles, then per-cycle recovery
  task automatic t_cycle();
    on_req = 1'h0;
    slew = 8'h19;
    cyc(2);
    oc_in = 1'h1;
    cmd_cyc = 1'h1;
    cyc(2);
    chk("blank short", 1'h1, gate_cyc);
    cyc(2);
    chk("blank long", 1'h1, gate_cyc);
    cyc(2);
    chk("cycle trip gate", 1'h0, gate_cyc);
    chk("cycle trip fault_n", 1'h0, fault_n_cyc);
    oc_in = 1'h0;
    slew = SLEW_DEFAULT;
    cyc(2);
    chk("cycle hold", 1'h0, gate_cyc);
    cmd_cyc = 1'h0;
    cyc(2);
    chk("cycle clear", 1'h1, fault_n_cyc);
    cmd_cyc = 1'h1;
    cyc(1);
    chk("cycle resume", 1'h1, gate_cyc);
    cmd_cyc = 1'h0;
    cyc(1);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(4);
    reset_i = 1'h0;
    t_start();
    t_latch();
    t_supply();
    t_temp();
    t_cycle();
    print_verdict();
  end
  initial begin
    #40us;
    error_cnt++;
    print_verdict();
  end
endmodule // psf_supervisor_bench
